/* hdl/afs_fault_clip.sv */
// fault status latches, current limit select and clip threshold registers
`timescale 1ns/100ps
`default_nettype none
module afs_fault_clip
  import afs_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          amp_shutdown_n,
  input  wire logic                          overcurrent_det,
  input  wire logic                          dc_offset_det,
  input  wire logic                          overtemp_det,
  input  wire logic                          clock_invalid_det,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output var  logic [7:0]                    reg_rdata,
  output var  logic                          reg_rsv_access,
  output var  logic [1:0]                    current_limit_select,
  output var  logic [afs_pkg::AFS_THR_W-1:0] clip_threshold_level,
  input  wire logic [afs_pkg::AFS_HI_W-1:0]  clip_level_high,
  output var  logic                          amp_run,
  input  wire afs_pkg::afs_sample_t          sample_in,
  input  wire logic                          sample_in_valid,
  output var  afs_pkg::afs_sample_t          sample_out,
  output var  logic                          sample_out_valid
);
  import afs_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic       sd_meta;
    logic       sd_sync;
    logic       sd_prev;
    logic [2:0] det_meta;
    logic [2:0] det_sync;
    logic       clk_meta;
    logic       clk_sync;
    logic       oc_flag;
    logic       dc_flag;
    logic       ot_flag;
    logic [1:0] sel;
    logic [7:0] clip_mid;
    logic [5:0] clip_low;
    logic [1:0] low_rsv;
    logic [7:0] rdata;
    logic       rsv;
  } afs_state_s;

  afs_state_s state_reg;
  afs_state_s state_next;
  logic       sd_toggled;

  // a full low-then-high cycle of shutdown counts as the toggle; a rising edge
  // is the moment the device leaves shutdown, so latched faults release there
  assign sd_toggled = state_reg.sd_sync & ~state_reg.sd_prev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next          = state_reg;
    state_next.sd_meta  = amp_shutdown_n;
    state_next.sd_sync  = state_reg.sd_meta;
    state_next.sd_prev  = state_reg.sd_sync;
    state_next.det_meta = {overcurrent_det, dc_offset_det, overtemp_det};
    state_next.det_sync = state_reg.det_meta;
    state_next.clk_meta = clock_invalid_det;
    state_next.clk_sync = state_reg.clk_meta;

    // toggle clears, but a detection in the same cycle still sets
    if (sd_toggled)
    begin
      state_next.oc_flag = 1'b0;
      state_next.dc_flag = 1'b0;
      state_next.ot_flag = 1'b0;
    end
    if (state_reg.det_sync[AFS_BIT_OVERCURRENT])
      state_next.oc_flag = 1'b1;
    if (state_reg.det_sync[AFS_BIT_DC_OFFSET])
      state_next.dc_flag = 1'b1;
    if (state_reg.det_sync[AFS_BIT_OVERTEMP])
      state_next.ot_flag = 1'b1;

    // writes to the fault register only reach the select field; flag bits ignore written data
    if (reg_wr)
    begin
      if (hit(reg_addr, AFS_ADDR_FAULT))
        state_next.sel = reg_wdata[AFS_SEL_LSB +: AFS_SEL_W];
      if (hit(reg_addr, AFS_ADDR_CLIP_MID))
        state_next.clip_mid = reg_wdata;
      if (hit(reg_addr, AFS_ADDR_CLIP_LOW))
      begin
        state_next.clip_low = reg_wdata[7:AFS_LOW_LSB];
        state_next.low_rsv  = reg_wdata[AFS_LOW_LSB-1:0];
      end
    end

    state_next.rsv   = (reg_wr | reg_rd) & (reg_addr >= AFS_ADDR_RSV_LO) & (reg_addr <= AFS_ADDR_RSV_HI);
    state_next.rdata = AFS_RD_UNMAPPED;
    if (reg_rd)
    begin
      if (hit(reg_addr, AFS_ADDR_FAULT))
      begin
        state_next.rdata[AFS_SEL_LSB +: AFS_SEL_W] = state_reg.sel;
        state_next.rdata[AFS_BIT_CLOCK_FAULT]      = state_reg.clk_sync;
        state_next.rdata[AFS_BIT_OVERCURRENT]      = state_reg.oc_flag;
        state_next.rdata[AFS_BIT_DC_OFFSET]        = state_reg.dc_flag;
        state_next.rdata[AFS_BIT_OVERTEMP]         = state_reg.ot_flag;
      end
      else if (hit(reg_addr, AFS_ADDR_CLIP_MID))
        state_next.rdata = state_reg.clip_mid;
      else if (hit(reg_addr, AFS_ADDR_CLIP_LOW))
        state_next.rdata = {state_reg.clip_low, state_reg.low_rsv};
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg          <= '0;
      state_reg.sel      <= AFS_SEL_RESET;
      state_reg.clip_mid <= AFS_CLIP_MID_RESET;
      state_reg.clip_low <= AFS_CLIP_LOW_RESET;
      state_reg.low_rsv  <= AFS_LOW_RSV_RESET;
    end
    else
      state_reg <= state_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata            = state_reg.rdata;
  assign reg_rsv_access       = state_reg.rsv;
  assign current_limit_select = state_reg.sel;
  assign clip_threshold_level = {clip_level_high, state_reg.clip_mid, state_reg.clip_low};
  // any latched fault or a present clock error holds the amplifier off
  assign amp_run = state_reg.sd_sync &
                   ~(state_reg.oc_flag | state_reg.dc_flag | state_reg.ot_flag | state_reg.clk_sync);

  afs_clipper u_clipper (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .clip_threshold_level (clip_threshold_level),
    .sample_in            (sample_in),
    .sample_in_valid      (sample_in_valid),
    .sample_out           (sample_out),
    .sample_out_valid     (sample_out_valid)
  );
endmodule : afs_fault_clip
`default_nettype wire

/* hdl/afs_pkg.sv */
// package of constants and types for the amplifier fault status and clip level block
// Function
// - over-current flag at bit 2 latches; blocks operation until shutdown toggles
// - dc offset flag at bit 1 latches; blocks operation until shutdown toggles
// - over-temperature flag at bit 0 latches; cleared only by shutdown toggle or reset
// - each fault flag sets to one when its quantity goes above threshold
// - fault flags are read-only; writes to their bits change nothing
// - 20-bit clip threshold is three fields: bits 19:14, 13:6, 5:0
// - register 0x10 bits 7:0 hold threshold bits 13:6
// - register 0x11 bits 7:2 hold threshold bits 5:0
// - host sets the clipping point through the programmable threshold
// - 2-bit select scales current limit: nominal, 75, 50, 25 percent
// - clock fault flag at bit 3 does not latch, clears by itself
package afs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] AFS_ADDR_FAULT    = 8'h08;
  localparam logic [7:0] AFS_ADDR_RSV_LO   = 8'h09;
  localparam logic [7:0] AFS_ADDR_RSV_HI   = 8'h0F;
  localparam logic [7:0] AFS_ADDR_CLIP_MID = 8'h10;
  localparam logic [7:0] AFS_ADDR_CLIP_LOW = 8'h11;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int AFS_BIT_OVERTEMP    = 0;
  localparam int AFS_BIT_DC_OFFSET   = 1;
  localparam int AFS_BIT_OVERCURRENT = 2;
  localparam int AFS_BIT_CLOCK_FAULT = 3;
  localparam int AFS_SEL_LSB  = 4;
  localparam int AFS_SEL_W    = 2;
  localparam int AFS_LOW_LSB  = 2;
  localparam int AFS_THR_W    = 20;
  localparam int AFS_HI_W     = 6;
  localparam int AFS_SMP_W    = 24;

  localparam logic [1:0] AFS_SEL_RESET      = 2'h0;
  localparam logic [7:0] AFS_CLIP_MID_RESET = 8'hFF;
  localparam logic [5:0] AFS_CLIP_LOW_RESET = 6'h3F;
  localparam logic [1:0] AFS_LOW_RSV_RESET  = 2'h0;
  localparam logic [7:0] AFS_RD_UNMAPPED    = 8'h00;

  typedef logic [AFS_SMP_W-1:0] afs_sample_t;

endpackage : afs_pkg

/* hdl/afs_clipper.sv */
// symmetric saturating clipper for one audio sample
`timescale 1ns/100ps
`default_nettype none
module afs_clipper
  import afs_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [afs_pkg::AFS_THR_W-1:0] clip_threshold_level,
  input  wire afs_pkg::afs_sample_t          sample_in,
  input  wire logic                          sample_in_valid,
  output var  afs_pkg::afs_sample_t          sample_out,
  output var  logic                          sample_out_valid
);
  import afs_pkg::*;

  typedef struct packed {
    afs_sample_t smp;
    logic        vld;
  } afs_clip_s;

  afs_clip_s state_reg;
  afs_clip_s state_next;
  afs_sample_t pos_lim;
  afs_sample_t neg_lim;

  // threshold sits at the bottom of the sample word
  assign pos_lim = {{(AFS_SMP_W-AFS_THR_W){1'b0}}, clip_threshold_level};
  assign neg_lim = afs_sample_t'(-$signed(pos_lim));

  always_comb
  begin
    state_next     = state_reg;
    state_next.vld = sample_in_valid;
    if (sample_in_valid)
    begin
      if ($signed(sample_in) > $signed(pos_lim))
        state_next.smp = pos_lim;
      else if ($signed(sample_in) < $signed(neg_lim))
        state_next.smp = neg_lim;
      else
        state_next.smp = sample_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sample_out       = state_reg.smp;
  assign sample_out_valid = state_reg.vld;
endmodule : afs_clipper
`default_nettype wire

/* sim/afs_fault_clip_properties.sv */
// port assertions for the fault status and clip level block
`timescale 1ns/100ps
`default_nettype none
module afs_fault_clip_properties
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        amp_shutdown_n,
  input wire logic        overcurrent_det,
  input wire logic        dc_offset_det,
  input wire logic        overtemp_det,
  input wire logic        clock_invalid_det,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rsv_access,
  input wire logic [1:0]  current_limit_select,
  input wire logic [19:0] clip_threshold_level,
  input wire logic [5:0]  clip_level_high,
  input wire logic        amp_run
);
  wire logic quiet = !(overcurrent_det | dc_offset_det | overtemp_det | clock_invalid_det);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ****
  // properties
  // ****
  sequence s_held(d); d[*5]; endsequence
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  property p_oc; s_held(overcurrent_det) |-> !amp_run; endproperty
  property p_dc; s_held(dc_offset_det) |-> !amp_run; endproperty
  property p_ot; s_held(overtemp_det) |-> !amp_run; endproperty
  property p_clk; s_held(clock_invalid_det) |-> !amp_run; endproperty
  // latched flags must go once shutdown has been toggled
  property p_clear;
    quiet[*4] ##0 $rose(amp_shutdown_n) ##1 (quiet && amp_shutdown_n)[*5] |-> amp_run;
  endproperty
  property p_rsv; (reg_wr || reg_rd) && reg_addr inside {[8'h09:8'h0F]} |=> reg_rsv_access; endproperty
  property p_sel; s_wr(8'h08) |=> {2'h0, current_limit_select, 4'h0} == ($past(reg_wdata) & 8'h30); endproperty
  property p_mid; s_wr(8'h10) |=> clip_threshold_level[13:6] == $past(reg_wdata); endproperty
  property p_low; s_wr(8'h11) |=> {clip_threshold_level[5:0], 2'h0} == ($past(reg_wdata) & 8'hFC); endproperty
  property p_high; clip_threshold_level[19:14] == clip_level_high; endproperty
  a_oc: assert property (p_oc) else $error("run after overcurrent");
  a_dc: assert property (p_dc) else $error("run after dc offset");
  a_ot: assert property (p_ot) else $error("run after overtemp");
  a_clk: assert property (p_clk) else $error("run with clock fault");
  a_clear: assert property (p_clear) else $error("no resume after toggle");
  a_rsv: assert property (p_rsv) else $error("reserved access not flagged");
  a_sel: assert property (p_sel) else $error("limit select wrong");
  a_mid: assert property (p_mid) else $error("threshold middle wrong");
  a_low: assert property (p_low) else $error("threshold low wrong");
  a_high: assert property (p_high) else $error("threshold top wrong");
endmodule : afs_fault_clip_properties
bind afs_fault_clip afs_fault_clip_properties i_props (.clk_sys, .reset_n, .amp_shutdown_n, .overcurrent_det,
  .dc_offset_det, .overtemp_det, .clock_invalid_det, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rsv_access,
  .current_limit_select, .clip_threshold_level, .clip_level_high, .amp_run);
`default_nettype wire

/* sim/afs_host_model.sv */
// control port master model
`timescale 1ns/100ps
`default_nettype none
module afs_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // address and data are inverted once released so nothing leans on stale values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : afs_host_model
`default_nettype wire

/* sim/afs_fault_clip_tb.sv */
// self-checking bench for the fault status and clip level block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module afs_fault_clip_tb;
  logic        clk_sys, reset_n, amp_shutdown_n, clock_invalid_det, reg_wr, reg_rd, reg_rsv_access, amp_run;
  logic [2:0]  det;
  logic [5:0]  clip_level_high;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
  logic [1:0]  current_limit_select;
  logic [19:0] clip_threshold_level;
  logic [23:0] sample_in, sample_out;
  logic        sample_in_valid, sample_out_valid;
  localparam logic [19:0] THR = {6'h2B, 8'hA5, 6'h17};
  int          mismatches, n_tests;
  afs_fault_clip i_dut (.clk_sys, .reset_n, .amp_shutdown_n, .overcurrent_det(det[2]), .dc_offset_det(det[1]),
    .overtemp_det(det[0]), .clock_invalid_det, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rsv_access, .current_limit_select, .clip_threshold_level, .clip_level_high, .amp_run,
    .sample_in, .sample_in_valid, .sample_out, .sample_out_valid);
  afs_host_model i_host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  // ****
  // tests
  // ****
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n
  // registers are set up while shutdown is held low
  task automatic t_regs;
    i_host.acc(1'b0, 8'h10, 8'h00, q);
    `CHK("mid reset", 8'hFF, q)
    i_host.acc(1'b0, 8'h11, 8'h00, q);
    `CHK("low reset", 8'hFC, q)
    i_host.acc(1'b1, 8'h10, 8'hA5, q);
    i_host.acc(1'b1, 8'h11, 8'h5C, q);
    `CHK("threshold", {clip_level_high, 8'hA5, 6'h17}, clip_threshold_level)
    i_host.acc(1'b0, 8'h0C, 8'h00, q);
    `CHK("reserved", 1'b1, reg_rsv_access)
    i_host.acc(1'b0, 8'h20, 8'h00, q);
    `CHK("unmapped", 8'h00, q)
    for (int i = 0; i < 4; i++)
    begin
      i_host.acc(1'b1, 8'h08, {2'b11, i[1:0], 4'hF}, q);
      i_host.acc(1'b0, 8'h08, 8'h00, q);
      `CHK("select", {2'b00, i[1:0], 4'h0}, q)
    end
    $display("t_regs done");
  endtask : t_regs
  // threshold programmed by t_regs; samples beyond it saturate on both sides
  task automatic t_clip;
    logic [23:0] lim;
    lim = {4'h0, THR};
    sample_in = 24'h7FFFFF;
    sample_in_valid = 1'b1;
    wait_n(1);
    `CHK("clip pos", lim, sample_out)
    `CHK("clip valid", 1'b1, sample_out_valid)
    sample_in = 24'h800000;
    wait_n(1);
    `CHK("clip neg", 24'h0 - lim, sample_out)
    sample_in = 24'h000123;
    wait_n(1);
    `CHK("clip pass", 24'h000123, sample_out)
    sample_in_valid = 1'b0;
    wait_n(1);
    `CHK("clip idle", 1'b0, sample_out_valid)
    `CHK("clip hold", 24'h000123, sample_out)
    $display("t_clip done");
  endtask : t_clip
  task automatic t_fault;
    amp_shutdown_n = 1'b1;
    wait_n(6);
    `CHK("run", 1'b1, amp_run)
    for (int k = 0; k < 3; k++)
    begin
      det[k] = 1'b1;
      wait_n(5);
      det[k] = 1'b0;
      wait_n(8);
      i_host.acc(1'b0, 8'h08, 8'h00, q);
      `CHK("flag", 8'h30 | (8'h01 << k), q)
      `CHK("stopped", 1'b0, amp_run)
      amp_shutdown_n = 1'b0;
      wait_n(4);
      amp_shutdown_n = 1'b1;
      wait_n(6);
      i_host.acc(1'b0, 8'h08, 8'h00, q);
      `CHK("cleared", 8'h30, q)
    end
    clock_invalid_det = 1'b1;
    wait_n(6);
    i_host.acc(1'b0, 8'h08, 8'h00, q);
    `CHK("clock flag", 8'h38, q)
    clock_invalid_det = 1'b0;
    wait_n(6);
    i_host.acc(1'b0, 8'h08, 8'h00, q);
    `CHK("clock gone", 8'h30, q)
    `CHK("resumed", 1'b1, amp_run)
    $display("t_fault done");
  endtask : t_fault
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // ****
  // run
  // ****
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    {reset_n, amp_shutdown_n, clock_invalid_det, det} = 6'h0;
    clip_level_high = 6'h2B;
    sample_in = 24'h000000;
    sample_in_valid = 1'b0;
    wait_n(5);
    reset_n = 1'b1;
    t_regs();
    t_clip();
    t_fault();
    end_sim();
  end
endmodule : afs_fault_clip_tb
`default_nettype wire
